// *** common/dtmd_pkg.sv ***
// Shared constants and types for the drive terminal mode decoder
package dtmd_pkg;

    // ----------------------------------------------------------------
    // Terminal indices
    // ----------------------------------------------------------------
    localparam int NUM_TERM = 9;
    localparam int T_PERMIT = 0;
    localparam int T_FWD = 1;
    localparam int T_REV = 2;
    localparam int T_IN3 = 3;
    localparam int T_IN4 = 4;
    localparam int T_IN5 = 5;
    localparam int T_IN6 = 6;
    localparam int T_IN7 = 7;
    localparam int T_TRIP = 8;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_FREQ_MHZ = 50;
    localparam int DEB_TIME_US = 10;
    localparam int DEB_CYCLES = DEB_TIME_US * CLK_FREQ_MHZ;
    localparam int DEB_CNT_W = $clog2(DEB_CYCLES + 1);

    // ----------------------------------------------------------------
    // Operating modes and codes
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_PRESET15 = 2'h0;
    localparam logic [1:0] MODE_FAN2W = 2'h1;
    localparam logic [1:0] MODE_FAN3W = 2'h2;
    localparam logic [3:0] CODE_FAULT_RESET = 4'hf;
    localparam logic [3:0] PRESET_FIRE = 4'h1;
    localparam logic [3:0] PRESET_FREEZE = 4'h2;
    localparam logic [3:0] PRESET_RST = 4'h1;
    localparam logic RAMP_RST = 1'h0;

    typedef enum logic [1:0] {SRC_PRESET, SRC_KEYPAD, SRC_CMD_PARAM, SRC_ANALOG1} dtmd_speed_src_t;
    typedef enum logic [1:0] {RUN_STOP, RUN_FWD, RUN_REV} dtmd_run_t;

endpackage : dtmd_pkg

// *** common/dtmd_term_if.sv ***
// Filtered terminal levels and edge pulses between filter and decoder
`timescale 1ns/10ps
interface dtmd_term_if import dtmd_pkg::*; ();
    logic [NUM_TERM-1:0] filt;
    logic [NUM_TERM-1:0] rise;
    logic [NUM_TERM-1:0] fall;

    modport src (output filt, output rise, output fall);
    modport dst (input filt, input rise, input fall);
endinterface : dtmd_term_if

// *** core/dtmd_decoder.sv ***
// Terminal strip decoder for preset-speed and fan/pump operating modes
`timescale 1ns/10ps

// Operation
// RULE_01: Run permit open disables the drive and lets the motor coast, in every mode.
// RULE_02: Two-wire: forward alone runs forward, reverse alone reverse; opening decelerates to stop.
// RULE_03: Fifteen-speed: inputs three to six form a code; n picks preset n+1, 1111 resets.
// RULE_04: Fifteen-speed: input seven closed picks ramp set 2, open picks ramp set 1.
// RULE_05: With trip protection on, an open trip terminal raises external trip; off ignores it.
// RULE_06: Fan/pump modes: forward and reverse closed together request a fault reset.
// RULE_07: Fan/pump modes: input four closed takes run commands from terminals, open from keypad.
// RULE_08: Switching between terminal and keypad keeps present speed and direction; two-wire keypad-to-terminal follows the forward/reverse levels.
// RULE_09: Fan/pump modes: fire override open forces preset speed 1.
// RULE_10: Fan/pump modes: fire closed and freeze override open forces preset speed 2.
// RULE_11: Fan/pump modes: both overrides closed and input five open take keypad speed.
// RULE_12: Fan/pump two-wire: all closed, input three picks analog input 1 or command source.
// RULE_13: Fan/pump three-wire: a momentary forward or reverse closure starts and holds running.
// RULE_14: Fan/pump three-wire: a momentary opening of input three decelerates and clears the run.
// RULE_15: Unipolar command source: forward or reverse moves; both closed stops motion.
// RULE_16: Fan/pump three-wire: all overrides and input five closed use the command source.
// RULE_17: Only the decoding of the programmed operating mode is applied.
// RULE_18: Terminals are synchronised, debounced, and edges taken from the filtered levels.
module dtmd_decoder import dtmd_pkg::*; #(
    parameter int DEB_CYCLES_P = DEB_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Terminal strip, one means closed
    input wire logic run_permit_terminal,
    input wire logic forward_terminal,
    input wire logic reverse_terminal,
    input wire logic input_three_terminal,
    input wire logic input_four_terminal,
    input wire logic input_five_terminal,
    input wire logic input_six_terminal,
    input wire logic input_seven_terminal,
    input wire logic trip_terminal,
    // Configuration
    input wire logic [1:0] op_mode,
    input wire logic ext_trip_enable,
    input wire logic cmd_unipolar,
    // Keypad commands, one-cycle pulses
    input wire logic keypad_start_fwd,
    input wire logic keypad_start_rev,
    input wire logic keypad_stop,
    input wire logic keypad_fault_reset,
    // Drive commands
    output logic drive_enable,
    output logic run_fwd,
    output logic run_rev,
    output logic stop_decel,
    output logic fault_reset,
    output logic ext_trip_fault,
    // Speed and ramp selection
    output dtmd_speed_src_t speed_src,
    output logic [3:0] preset_sel,
    output logic ramp_set2,
    output logic control_from_keypad,
    output logic speed_from_keypad,
    output logic speed_hold
);

    // ----------------------------------------------------------------
    // Terminal filtering
    // ----------------------------------------------------------------
    dtmd_term_if term ();

    dtmd_term_filter #(
        .DEB_CYCLES_P(DEB_CYCLES_P)
    ) u_dtmd_term_filter (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .raw({trip_terminal, input_seven_terminal, input_six_terminal, input_five_terminal,
              input_four_terminal, input_three_terminal, reverse_terminal, forward_terminal,
              run_permit_terminal}),
        .term(term.src)
    );

    logic permit;
    logic fwd;
    logic rev;
    logic in3;
    logic in4;
    logic in5;
    logic fire_override;
    logic freeze_override;
    logic trip;
    logic fwd_rise;
    logic rev_rise;
    logic stop_fall;
    logic [3:0] code;
    logic p15;
    logic fan;
    logic fan3;
    logic tctl;

    assign permit = term.filt[T_PERMIT];
    assign fwd = term.filt[T_FWD];
    assign rev = term.filt[T_REV];
    assign in3 = term.filt[T_IN3];
    assign in4 = term.filt[T_IN4];
    assign in5 = term.filt[T_IN5];
    assign fire_override = term.filt[T_IN6];
    assign freeze_override = term.filt[T_IN7];
    assign trip = term.filt[T_TRIP];
    assign fwd_rise = term.rise[T_FWD];
    assign rev_rise = term.rise[T_REV];
    assign stop_fall = term.fall[T_IN3];
    assign code = term.filt[T_IN6:T_IN3];
    assign p15 = (op_mode == MODE_PRESET15);
    assign fan3 = (op_mode == MODE_FAN3W);
    assign fan = (op_mode == MODE_FAN2W) || fan3;
    // Fifteen-speed mode always listens to the terminals
    assign tctl = p15 || (fan && in4);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        dtmd_run_t run;
        logic [3:0] preset_sel;
        dtmd_speed_src_t speed_src;
        logic ramp_set2;
        logic ext_trip;
        logic fault_reset;
        logic reset_cond;
        logic kp_ctrl;
        logic kp_speed;
        logic speed_hold;
        logic stop_decel;
        logic [1:0] mode;
        logic enable;
    } dtmd_core_state_t;

    localparam dtmd_core_state_t CORE_RST = '{
        run: RUN_STOP,
        preset_sel: PRESET_RST,
        speed_src: SRC_PRESET,
        ramp_set2: RAMP_RST,
        mode: MODE_PRESET15,
        default: 1'b0
    };

    dtmd_core_state_t s;
    dtmd_core_state_t next_s;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.fault_reset = 1'b0;
        next_s.stop_decel = 1'b0;
        next_s.mode = op_mode;
        next_s.enable = permit; // RULE_01
        next_s.ext_trip = ext_trip_enable && !trip; // RULE_05
        next_s.kp_ctrl = fan && !in4; // RULE_07

        // Fault reset requests, pulsed once per assertion
        if (p15) begin
            next_s.reset_cond = (code == CODE_FAULT_RESET); // RULE_03
        end else if (fan) begin
            next_s.reset_cond = tctl ? (fwd && rev) : keypad_fault_reset; // RULE_06 RULE_07
        end else begin
            next_s.reset_cond = 1'b0; // RULE_17
        end
        next_s.fault_reset = next_s.reset_cond && !s.reset_cond;

        // Speed source and ramp set
        if (p15) begin
            next_s.ramp_set2 = freeze_override; // RULE_04
            if (code != CODE_FAULT_RESET) begin
                next_s.speed_src = SRC_PRESET; // RULE_03
                next_s.preset_sel = code + 4'h1; // RULE_03
            end
        end else if (fan) begin
            next_s.ramp_set2 = RAMP_RST;
            if (!fire_override) begin
                next_s.speed_src = SRC_PRESET; // RULE_09
                next_s.preset_sel = PRESET_FIRE; // RULE_09
            end else if (!freeze_override) begin
                next_s.speed_src = SRC_PRESET; // RULE_10
                next_s.preset_sel = PRESET_FREEZE; // RULE_10
            end else if (!in5) begin
                next_s.speed_src = SRC_KEYPAD; // RULE_11
            end else if (!fan3 && in3) begin
                next_s.speed_src = SRC_ANALOG1; // RULE_12
            end else begin
                next_s.speed_src = SRC_CMD_PARAM; // RULE_12 RULE_16
            end
        end
        next_s.kp_speed = (next_s.speed_src == SRC_KEYPAD);
        // The ramp must load the present speed as the new reference on a handover
        next_s.speed_hold = (next_s.kp_speed != s.kp_speed) || (next_s.kp_ctrl != s.kp_ctrl); // RULE_08

        // Run state
        if (!permit || op_mode != s.mode || !(p15 || fan)) begin
            next_s.run = RUN_STOP; // RULE_01 RULE_17
        end else if (!tctl) begin
            // Keypad control inherits whatever the terminals left running
            if (keypad_stop) begin
                next_s.run = RUN_STOP;
            end else if (keypad_start_fwd) begin
                next_s.run = RUN_FWD;
            end else if (keypad_start_rev) begin
                next_s.run = RUN_REV;
            end else begin
                next_s.run = s.run; // RULE_08
            end
        end else if (fan3) begin
            if (stop_fall || !in3) begin
                next_s.run = RUN_STOP; // RULE_14
            end else if (fwd && rev) begin
                next_s.run = cmd_unipolar ? RUN_STOP : s.run; // RULE_15
            end else if (fwd_rise) begin
                next_s.run = RUN_FWD; // RULE_13
            end else if (rev_rise) begin
                next_s.run = RUN_REV; // RULE_13
            end else begin
                next_s.run = s.run; // RULE_13
            end
        end else begin
            if (fwd && !rev) begin
                next_s.run = RUN_FWD; // RULE_02
            end else if (rev && !fwd) begin
                next_s.run = RUN_REV; // RULE_02
            end else if (fwd && rev) begin
                next_s.run = cmd_unipolar ? RUN_STOP : s.run; // RULE_15
            end else begin
                next_s.run = RUN_STOP; // RULE_02
            end
        end
        // Decel only for commanded stops; permit loss or mode change coasts
        next_s.stop_decel = (next_s.run == RUN_STOP) && (s.run != RUN_STOP) && permit
            && (op_mode == s.mode) && (p15 || fan); // RULE_02 RULE_14
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s <= CORE_RST;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign drive_enable = s.enable;
    assign run_fwd = (s.run == RUN_FWD);
    assign run_rev = (s.run == RUN_REV);
    assign stop_decel = s.stop_decel;
    assign fault_reset = s.fault_reset;
    assign ext_trip_fault = s.ext_trip;
    assign speed_src = s.speed_src;
    assign preset_sel = s.preset_sel;
    assign ramp_set2 = s.ramp_set2;
    assign control_from_keypad = s.kp_ctrl;
    assign speed_from_keypad = s.kp_speed;
    assign speed_hold = s.speed_hold;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    sequence fwd_start_s;
        fan3 && tctl && permit && in3 && fwd_rise && !rev && !stop_fall && op_mode == s.mode;
    endsequence

    sequence run_quiet_s;
        fan3 && tctl && permit && in3 && !rev_rise && !fwd_rise && !(fwd && rev) && $stable(op_mode);
    endsequence

    permit_coast_a: assert property (!permit |=> !drive_enable && !run_fwd && !run_rev && !stop_decel) // RULE_01
        else $error("Open permit did not coast the motor");

    two_wire_fwd_a: assert property ( // RULE_02
        (p15 || (op_mode == MODE_FAN2W && in4)) && permit && fwd && !rev && op_mode == s.mode
        |=> run_fwd and (!fwd && tctl |=> !run_fwd))
        else $error("Two-wire forward level not followed");

    preset_code_a: assert property ( // RULE_03
        p15 && code != CODE_FAULT_RESET |=> preset_sel == $past(code) + 4'h1 && speed_src == SRC_PRESET)
        else $error("Preset code not decoded to preset n+1");

    preset_reset_a: assert property ( // RULE_03
        p15 && code == CODE_FAULT_RESET && !s.reset_cond |=> fault_reset ##1 !fault_reset)
        else $error("Code 1111 did not give a single fault reset pulse");

    ramp_select_a: assert property (p15 |=> ramp_set2 == $past(freeze_override)) // RULE_04
        else $error("Ramp set does not follow input seven");

    ext_trip_a: assert property (##1 ext_trip_fault == $past(ext_trip_enable && !trip)) // RULE_05
        else $error("External trip not gated by its enable");

    fan_reset_a: assert property ( // RULE_06
        fan && in4 && fwd && rev && !s.reset_cond |=> fault_reset)
        else $error("Forward and reverse together gave no fault reset");

    keypad_ctrl_a: assert property (fan && !in4 |=> control_from_keypad) // RULE_07
        else $error("Input four open did not hand control to keypad");

    handover_keep_a: assert property ( // RULE_08
        fan && !in4 && permit && op_mode == s.mode && !keypad_stop && !keypad_start_fwd && !keypad_start_rev
        |=> $stable(run_fwd) && $stable(run_rev))
        else $error("Direction changed across a source handover");

    handover_hold_a: assert property ( // RULE_08
        ##1 ($changed(control_from_keypad) || $changed(speed_from_keypad)) |-> speed_hold)
        else $error("Source handover without speed hold");

    fire_preset_a: assert property (fan && !fire_override |=> speed_src == SRC_PRESET && preset_sel == PRESET_FIRE) // RULE_09
        else $error("Fire override did not force preset 1");

    freeze_preset_a: assert property ( // RULE_10
        fan && fire_override && !freeze_override |=> speed_src == SRC_PRESET && preset_sel == PRESET_FREEZE)
        else $error("Freeze override did not force preset 2");

    keypad_speed_a: assert property (fan && fire_override && freeze_override && !in5 |=> speed_from_keypad) // RULE_11
        else $error("Keypad speed not selected");

    analog_select_a: assert property ( // RULE_12
        op_mode == MODE_FAN2W && fire_override && freeze_override && in5
        |=> speed_src == ($past(in3) ? SRC_ANALOG1 : SRC_CMD_PARAM))
        else $error("Analog or command source selection wrong");

    latch_start_a: assert property (fwd_start_s ##1 run_quiet_s |=> run_fwd) // RULE_13
        else $error("Momentary forward did not hold the run");

    stop_clear_a: assert property ( // RULE_14
        fan3 && in4 && permit && run_fwd && stop_fall && op_mode == s.mode |=> !run_fwd && !run_rev && stop_decel)
        else $error("Stop opening did not decelerate and clear the run");

    both_stop_a: assert property (cmd_unipolar && tctl && fwd && rev |=> !run_fwd && !run_rev) // RULE_15
        else $error("Both directions closed did not stop motion");

    param_source_a: assert property (fan3 && fire_override && freeze_override && in5 |=> speed_src == SRC_CMD_PARAM) // RULE_16
        else $error("Three-wire did not select command source");

    mode_only_a: assert property (!(p15 || fan) |=> !run_fwd && !run_rev && !fault_reset) // RULE_17
        else $error("Unsupported mode produced a command");

endmodule : dtmd_decoder

// *** core/dtmd_term_filter.sv ***
// Terminal synchroniser, debounce filter and edge detector
`timescale 1ns/10ps
module dtmd_term_filter import dtmd_pkg::*; #(
    parameter int DEB_CYCLES_P = DEB_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Raw terminals, one means closed
    input wire logic [NUM_TERM-1:0] raw,
    // Filtered view
    dtmd_term_if.src term
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [NUM_TERM-1:0] sync1;
        logic [NUM_TERM-1:0] sync2;
        logic [NUM_TERM-1:0] filt;
        logic [NUM_TERM-1:0] rise;
        logic [NUM_TERM-1:0] fall;
        logic [NUM_TERM-1:0][DEB_CNT_W-1:0] cnt;
    } dtmd_filt_state_t;

    localparam logic [DEB_CNT_W-1:0] DEB_LAST = DEB_CNT_W'(DEB_CYCLES_P - 1);

    dtmd_filt_state_t s;
    dtmd_filt_state_t next_s;

    // ----------------------------------------------------------------
    // Per-terminal filtering
    // ----------------------------------------------------------------
    // Only sync2 is looked at; sync1 may be metastable
    always_comb begin
        next_s = s;
        next_s.sync1 = raw;
        next_s.sync2 = s.sync1;
        next_s.rise = '0;
        next_s.fall = '0;
        for (int i = 0; i < NUM_TERM; i++) begin
            if (s.sync2[i] == s.filt[i]) begin
                next_s.cnt[i] = '0;
            end else if (s.cnt[i] == DEB_LAST) begin
                next_s.cnt[i] = '0;
                next_s.filt[i] = s.sync2[i]; // RULE_18
                next_s.rise[i] = s.sync2[i]; // RULE_18
                next_s.fall[i] = !s.sync2[i]; // RULE_18
            end else begin
                next_s.cnt[i] = s.cnt[i] + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign term.filt = s.filt;
    assign term.rise = s.rise;
    assign term.fall = s.fall;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    edge_marks_change_a: assert property ( // RULE_18
        @(posedge sys_clk) disable iff (!nrst)
        ((s.filt ^ $past(s.filt)) == (s.rise | s.fall)) && ((s.rise & ~s.filt) == '0))
        else $error("Edge pulse does not match filtered level change");

endmodule : dtmd_term_filter

// *** dv/drive_terminal_mode_decoder_test.sv ***
// Self-checking bench for the drive terminal mode decoder
`timescale 1ns/10ps
module drive_terminal_mode_decoder_test import dtmd_pkg::*; ;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    // Short debounce keeps the run small; every settle wait is derived from it, the 20000-cycle timeout is fixed
    localparam int DEB = 3;
    localparam int SETTLE = DEB + 8;
    logic sys_clk, nrst, trip_en, unip, kp_f, kp_r, kp_s, kp_fr;
    logic [NUM_TERM-1:0] want, bounce, term;
    logic [1:0] op_mode;
    logic drive_enable, run_fwd, run_rev, stop_decel, fault_reset, ext_trip_fault;
    logic ramp_set2, control_from_keypad, speed_from_keypad, speed_hold;
    dtmd_speed_src_t speed_src;
    logic [3:0] preset_sel;
    logic [31:0] r;
    int error_cnt, checks_done, fr_n, sd_n, sh_n, de_lo, b0, b1;

    dtmd_switch_bank u_dtmd_switch_bank (.sys_clk(sys_clk), .want(want), .bounce(bounce), .term(term));
    dtmd_decoder #(.DEB_CYCLES_P(DEB)) u_dtmd_decoder (
        .sys_clk(sys_clk), .nrst(nrst), .run_permit_terminal(term[T_PERMIT]), .forward_terminal(term[T_FWD]),
        .reverse_terminal(term[T_REV]), .input_three_terminal(term[T_IN3]), .input_four_terminal(term[T_IN4]),
        .input_five_terminal(term[T_IN5]), .input_six_terminal(term[T_IN6]), .input_seven_terminal(term[T_IN7]),
        .trip_terminal(term[T_TRIP]), .op_mode(op_mode), .ext_trip_enable(trip_en), .cmd_unipolar(unip),
        .keypad_start_fwd(kp_f), .keypad_start_rev(kp_r), .keypad_stop(kp_s), .keypad_fault_reset(kp_fr),
        .drive_enable(drive_enable), .run_fwd(run_fwd), .run_rev(run_rev), .stop_decel(stop_decel),
        .fault_reset(fault_reset), .ext_trip_fault(ext_trip_fault), .speed_src(speed_src),
        .preset_sel(preset_sel), .ramp_set2(ramp_set2), .control_from_keypad(control_from_keypad),
        .speed_from_keypad(speed_from_keypad), .speed_hold(speed_hold));

    // ----------------------------------------------------------------
    // Clock, pulse counters, helpers
    // ----------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // Pulses are counted so a test only compares counts, never races an edge
    always @(posedge sys_clk) begin
        fr_n <= fr_n + int'(fault_reset === 1'b1);
        sd_n <= sd_n + int'(stop_decel === 1'b1);
        sh_n <= sh_n + int'(speed_hold === 1'b1);
        de_lo <= de_lo + int'(drive_enable === 1'b0);
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : chk
    task automatic settle();
        repeat (SETTLE) @(posedge sys_clk);
    endtask : settle
    task automatic kpulse(input int k);
        @(posedge sys_clk);
        {kp_fr, kp_s, kp_r, kp_f} <= 4'h1 << k;
        @(posedge sys_clk);
        {kp_fr, kp_s, kp_r, kp_f} <= 4'h0;
        settle();
    endtask : kpulse
    function automatic logic [1:0] exp_src(input logic [NUM_TERM-1:0] w, input logic [1:0] m);
        if (!w[T_IN6] || !w[T_IN7]) return SRC_PRESET;
        if (!w[T_IN5]) return SRC_KEYPAD;
        if (m == MODE_FAN2W && w[T_IN3]) return SRC_ANALOG1;
        return SRC_CMD_PARAM;
    endfunction : exp_src
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        $display("BAD t=%0t run timed out", $time);
        complete_run();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {nrst, trip_en, unip, kp_f, kp_r, kp_s, kp_fr} = 7'h0;
        {error_cnt, checks_done, fr_n, sd_n, sh_n, de_lo} = {6{32'sd0}};
        want = '0;
        bounce = '0;
        op_mode = MODE_PRESET15;
        r = $urandom(32'he86f3ac9);
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        want <= (NUM_TERM'(1) << T_PERMIT) | (NUM_TERM'(1) << T_FWD) | (NUM_TERM'(1) << T_TRIP);
        settle();
        chk(run_fwd, 1'b1, "fwd run");
        for (int n = 0; n < 16; n++) begin
            r = $urandom;
            want[T_IN6:T_IN3] <= n[3:0];
            want[T_IN7] <= r[0];
            b0 = fr_n;
            settle();
            if (n < 15) chk(preset_sel, 8'(n + 1), "preset");
            else chk(8'(fr_n - b0), 8'h1, "code reset");
            chk(ramp_set2, want[T_IN7], "ramp");
        end
        b0 = sd_n;
        want[T_FWD] <= 1'b0;
        settle();
        chk({run_fwd, 4'(sd_n - b0)}, 8'h01, "fwd open");
        {unip, want[T_REV]} <= 2'h3;
        settle();
        want[T_FWD] <= 1'b1;
        settle();
        chk({run_fwd, run_rev}, 2'h0, "both unipolar");
        {unip, want[T_FWD]} <= 2'h0;
        settle();
        b0 = sd_n;
        want[T_PERMIT] <= 1'b0;
        settle();
        chk({drive_enable, run_rev, 4'(sd_n - b0)}, 8'h00, "coast");
        want[T_PERMIT] <= 1'b1;
        settle();
        chk(run_rev, 1'b1, "rev run");
        $display("test two_wire done");
        {trip_en, want[T_TRIP]} <= 2'h2;
        settle();
        chk(ext_trip_fault, 1'b1, "trip on");
        trip_en <= 1'b0;
        settle();
        chk(ext_trip_fault, 1'b0, "trip off");
        b0 = de_lo;
        {trip_en, want[T_TRIP]} <= 2'h3;
        bounce[T_PERMIT] <= 1'b1;
        @(posedge sys_clk);
        bounce[T_PERMIT] <= 1'b0;
        settle();
        chk({ext_trip_fault, 4'(de_lo - b0)}, 8'h00, "glitch");
        want[T_REV] <= 1'b0;
        want[T_IN4] <= 1'b1;
        $display("test trip_glitch done");
        for (int m = 1; m < 3; m++) begin
            op_mode <= 2'(m);
            for (int i = 0; i < 12; i++) begin
                r = (i == 0) ? 32'hf : (i == 1) ? 32'hc : $urandom;
                {want[T_IN7], want[T_IN6], want[T_IN5], want[T_IN3]} <= r[3:0];
                settle();
                chk(speed_src, exp_src(want, op_mode), "source");
                chk(speed_from_keypad, exp_src(want, op_mode) == SRC_KEYPAD, "kp speed");
                if (!want[T_IN6] || !want[T_IN7]) chk(preset_sel, want[T_IN6] ? PRESET_FREEZE : PRESET_FIRE, "ovr");
                chk(ramp_set2, 1'b0, "fan ramp");
            end
        end
        $display("test fan_speed done");
        {want[T_IN3], want[T_FWD]} <= 2'h3;
        settle();
        want[T_FWD] <= 1'b0;
        settle();
        chk(run_fwd, 1'b1, "latched fwd");
        b0 = sd_n;
        want[T_IN3] <= 1'b0;
        settle();
        want[T_IN3] <= 1'b1;
        settle();
        chk({run_fwd, 4'(sd_n - b0)}, 8'h01, "stop tap");
        b0 = fr_n;
        {want[T_REV], want[T_FWD]} <= 2'h3;
        settle();
        {want[T_REV], want[T_FWD]} <= 2'h0;
        settle();
        chk(8'(fr_n - b0), 8'h1, "both reset");
        want[T_REV] <= 1'b1;
        settle();
        want[T_REV] <= 1'b0;
        settle();
        chk(run_rev, 1'b1, "latched rev");
        b0 = sh_n;
        want[T_IN4] <= 1'b0;
        settle();
        chk({control_from_keypad, run_rev, 4'(sh_n - b0)}, 8'h31, "handover");
        kpulse(0);
        chk(run_fwd, 1'b1, "keypad fwd");
        b1 = fr_n;
        kpulse(3);
        chk(8'(fr_n - b1), 8'h1, "keypad reset");
        kpulse(2);
        chk(run_fwd, 1'b0, "keypad stop");
        kpulse(1);
        chk(run_rev, 1'b1, "keypad rev");
        op_mode <= 2'h3;
        settle();
        chk(run_rev, 1'b0, "no mode");
        $display("test three_wire_keypad done");
        complete_run();
    end
endmodule : drive_terminal_mode_decoder_test

// *** dv/dtmd_switch_bank.sv ***
// Switch bank model that drives the terminal strip
`timescale 1ns/10ps
module dtmd_switch_bank import dtmd_pkg::*; (
    // Clock
    input wire logic sys_clk,
    // Requested contacts, one means closed; bounce flips a contact for one cycle
    input wire logic [NUM_TERM-1:0] want,
    input wire logic [NUM_TERM-1:0] bounce,
    // Terminal strip
    output logic [NUM_TERM-1:0] term
);
    // Contacts move just after the edge, like any remote logic output would
    always @(posedge sys_clk) begin
        term <= want ^ bounce;
    end
endmodule : dtmd_switch_bank
